// ==== core/csl_charger_top.sv ====
// Charger status, source select and safety timer with Wishbone registers
//
// Behaviour
// - Status pins only pull low or float; never drive high.
// - Charging phases: A low, B float, PG low; faults pull all low.
// - Charge complete standby: A float, B low, PG low.
// - Shut down on input or no battery: both indicators float, PG low.
// - No input or shut down on battery: all float; low battery: A only.
// - Source select low: USB input, limit from USB limit select.
// - Source select high: wall adapter, 1.8A cap, programmed charge current.
// - USB limit select low: 100 mA limit.
// - USB limit select high: 500 mA limit.
// - Power-good low when input above lockout and above battery.
// - Safety timer runs while its enable input is low.
// - Temperature fault stops charge, holds timer, resumes when in range.
// - Termination latches charge off and enters charge complete.
`timescale 1ns/1ps

module csl_charger_top #(
  parameter int TICK_CYCLES = csl_pkg::TICK_CYCLES,
  parameter int unsigned SAFETY_TIMER_MS = csl_pkg::SAFETY_TIMER_MS
) (
  input wire logic clk_sys_in, // 125 MHz system clock
  input wire logic reset_n_in, // Asynchronous reset, active low
  // Wishbone slave
  input wire logic wb_cyc_in, // Bus cycle
  input wire logic wb_stb_in, // Strobe
  input wire logic wb_we_in, // Write enable
  input wire logic [7:0] wb_adr_in, // Byte address
  input wire logic [3:0] wb_sel_in, // Byte selects
  input wire logic [31:0] wb_dat_in, // Write data
  output logic [31:0] wb_dat_out, // Read data
  output logic wb_ack_out, // Acknowledge
  // Analog comparator results and control pins
  input wire logic above_undervoltage_lockout_in, // Input above undervoltage_lockout
  input wire logic above_bat_in, // Input above battery voltage
  input wire logic battery_present_in, // Battery detected
  input wire logic thermistor_sense_ok_in, // Thermistor voltage in range
  input wire logic below_precond_in, // Battery below precondition level
  input wire logic at_reg_voltage_in, // Battery at regulation voltage
  input wire logic termination_in, // Charge current below termination
  input wire logic below_recharge_in, // Battery below recharge level
  input wire logic low_battery_in, // Battery low on battery supply
  input wire logic source_select_in, // High wall adapter, low USB
  input wire logic usb_limit_select_in, // High 500 mA, low 100 mA
  input wire logic safety_timer_enable_n_in, // Low enables timer
  // Open-drain status pins
  input wire logic charge_indicator_a_in, // Pin level A
  output logic charge_indicator_a_out, // Drive value A
  output logic charge_indicator_a_oe_out, // Pull A low
  input wire logic charge_indicator_b_in, // Pin level B
  output logic charge_indicator_b_out, // Drive value B
  output logic charge_indicator_b_oe_out, // Pull B low
  input wire logic input_power_good_n_in, // Pin level power-good
  output logic input_power_good_n_out, // Drive value power-good
  output logic input_power_good_n_oe_out, // Pull power-good low
  // Charge path controls
  output logic [10:0] input_limit_ma_out, // Input current cap in mA
  output logic fast_charge_program_out, // Programmed charge current applies
  output logic charge_enable_out, // Pass transistor on
  output logic precond_current_out // Reduced preconditioning current
);

  // ==========================================================
  // Reset release
  logic rst_meta_ff;
  logic rst_n_ff;

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // ==========================================================
  // Input synchronisation
  logic [csl_pkg::COND_WIDTH-1:0] cond_raw;
  logic [csl_pkg::COND_WIDTH-1:0] cond;

  assign cond_raw = {
    input_power_good_n_in, charge_indicator_b_in, charge_indicator_a_in,
    safety_timer_enable_n_in, usb_limit_select_in, source_select_in,
    low_battery_in, below_recharge_in, termination_in, at_reg_voltage_in,
    below_precond_in, thermistor_sense_ok_in, battery_present_in,
    above_bat_in, above_undervoltage_lockout_in
  };

  csl_pin_sync #(
    .WIDTH(csl_pkg::COND_WIDTH),
    .RESET_VAL(csl_pkg::COND_RESET)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(rst_n_ff),
    .pin_in(cond_raw),
    .level_out(cond)
  );

  wire power_good = cond[csl_pkg::COND_ABOVE_UNDERVOLTAGE_LOCKOUT] & cond[csl_pkg::COND_ABOVE_BAT];
  wire thermistor_sense_ok = cond[csl_pkg::COND_THERMISTOR_SENSE_OK];
  wire bat_present = cond[csl_pkg::COND_BAT_PRESENT];
  wire use_wall = cond[csl_pkg::COND_SOURCE_SEL];

  // ==========================================================
  // Control register
  logic [1:0] ctrl_ff;
  logic restart_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;

  wire shutdown_req = ctrl_ff[csl_pkg::CTRL_SHUTDOWN_BIT];
  wire timer_sw_off = ctrl_ff[csl_pkg::CTRL_TIMER_OFF_BIT];

  // ==========================================================
  // Millisecond tick divider
  logic [16:0] tick_cnt_ff;
  logic tick_ff;

  wire tick_wrap = (tick_cnt_ff == 17'(TICK_CYCLES - 1));

  always_ff @(posedge clk_sys_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      tick_cnt_ff <= 17'h00000;
      tick_ff <= 1'b0;
    end else begin
      tick_cnt_ff <= tick_wrap ? 17'h00000 : tick_cnt_ff + 17'h00001;
      tick_ff <= tick_wrap;
    end
  end

  // ==========================================================
  // Charge state machine
  csl_pkg::csl_state_t state_ff;
  csl_pkg::csl_state_t nxt_state;
  logic [31:0] timer_ms_ff;

  // Phase to charge in, picked from the battery voltage
  function automatic csl_pkg::csl_state_t charge_phase(input logic [14:0] c);
    if (c[csl_pkg::COND_BELOW_PRECOND]) begin
      charge_phase = csl_pkg::st_precond;
    end else if (c[csl_pkg::COND_AT_REG_VOLT]) begin
      charge_phase = csl_pkg::st_const_voltage;
    end else begin
      charge_phase = csl_pkg::st_const_current;
    end
  endfunction : charge_phase

  function automatic logic is_charging(input csl_pkg::csl_state_t s);
    is_charging = (s == csl_pkg::st_precond) || (s == csl_pkg::st_const_current)
               || (s == csl_pkg::st_const_voltage);
  endfunction : is_charging

  wire timer_expired = (timer_ms_ff >= 32'(SAFETY_TIMER_MS));
  wire idle_state = !is_charging(state_ff) && (state_ff != csl_pkg::st_complete)
                 && (state_ff != csl_pkg::st_temp_fault)
                 && (state_ff != csl_pkg::st_timer_fault);

  always_comb begin
    nxt_state = state_ff;
    if (!power_good) begin
      if (shutdown_req) begin
        nxt_state = csl_pkg::st_shut_bat;
      end else if (cond[csl_pkg::COND_LOW_BATTERY]) begin
        nxt_state = csl_pkg::st_low_bat;
      end else begin
        nxt_state = csl_pkg::st_no_input;
      end
    end else if (shutdown_req) begin
      nxt_state = csl_pkg::st_shut_in;
    end else if (!bat_present) begin
      nxt_state = csl_pkg::st_no_bat;
    end else begin
      case (state_ff)
        csl_pkg::st_precond,
        csl_pkg::st_const_current,
        csl_pkg::st_const_voltage: begin
          if (!thermistor_sense_ok) begin
            nxt_state = csl_pkg::st_temp_fault;
          end else if (timer_expired) begin
            nxt_state = csl_pkg::st_timer_fault;
          end else if (cond[csl_pkg::COND_AT_REG_VOLT] && cond[csl_pkg::COND_TERMINATION]) begin
            nxt_state = csl_pkg::st_complete;
          end else begin
            nxt_state = charge_phase(cond);
          end
        end
        csl_pkg::st_temp_fault: begin
          if (thermistor_sense_ok) begin
            nxt_state = charge_phase(cond);
          end
        end
        csl_pkg::st_complete: begin
          if (cond[csl_pkg::COND_BELOW_RECHARGE]) begin
            nxt_state = charge_phase(cond);
          end
        end
        csl_pkg::st_timer_fault: begin
          // Latched until software restarts or shuts down, the input drops or the battery is removed
          if (restart_ff) begin
            nxt_state = charge_phase(cond);
          end
        end
        default: begin
          nxt_state = thermistor_sense_ok ? charge_phase(cond) : csl_pkg::st_temp_fault;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= csl_pkg::st_no_input;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // Safety timer
  // A fresh cycle clears it; a temperature fault only pauses it.
  wire new_cycle = is_charging(nxt_state) && (idle_state
                || (state_ff == csl_pkg::st_complete)
                || (state_ff == csl_pkg::st_timer_fault));
  // count only while enable input is low
  wire timer_run = is_charging(state_ff) && !cond[csl_pkg::COND_TIMER_EN_N]
                && !timer_sw_off && tick_ff && !timer_expired;

  always_ff @(posedge clk_sys_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      timer_ms_ff <= 32'h00000000;
    end else if (new_cycle) begin
      timer_ms_ff <= 32'h00000000;
    end else if (timer_run) begin
      timer_ms_ff <= timer_ms_ff + 32'h00000001;
    end
  end

  // ==========================================================
  // Source selection and charge path
  // USB limit chosen by the select input
  wire [10:0] usb_limit = cond[csl_pkg::COND_USB_LIMIT_SEL] ? csl_pkg::USB_HIGH_LIMIT_MA
                                                           : csl_pkg::USB_LOW_LIMIT_MA;
  // wall adapter caps at 1.8A, else USB limit
  wire [10:0] nxt_limit = use_wall ? csl_pkg::WALL_LIMIT_MA : usb_limit;
  wire nxt_charge_en = is_charging(state_ff);

  always_ff @(posedge clk_sys_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      input_limit_ma_out <= csl_pkg::USB_LOW_LIMIT_MA;
      fast_charge_program_out <= 1'b0;
      charge_enable_out <= 1'b0;
      precond_current_out <= 1'b0;
    end else begin
      input_limit_ma_out <= nxt_limit;
      fast_charge_program_out <= use_wall;
      charge_enable_out <= nxt_charge_en;
      precond_current_out <= (state_ff == csl_pkg::st_precond);
    end
  end

  // ==========================================================
  // Status pins
  logic pull_a;
  logic pull_b;
  logic pull_pg;

  csl_status_enc u_enc (
    .state_in(state_ff),
    .pull_a_out(pull_a),
    .pull_b_out(pull_b),
    .pull_pg_out(pull_pg)
  );

  // drive value is always low; only enable toggles
  // a high level relies on external pull-ups
  assign charge_indicator_a_out = 1'b0;
  assign charge_indicator_b_out = 1'b0;
  assign input_power_good_n_out = 1'b0;
  assign charge_indicator_a_oe_out = pull_a;
  assign charge_indicator_b_oe_out = pull_b;
  // power-good pulled only with valid input
  assign input_power_good_n_oe_out = pull_pg & power_good;

  // ==========================================================
  // Wishbone slave
  wire bus_req = wb_cyc_in & wb_stb_in & ~ack_ff;
  // Writes land on the edge at which the master samples ack high
  wire bus_wr = wb_cyc_in & wb_stb_in & wb_we_in & ack_ff;
  wire sel_ctrl = (wb_adr_in == csl_pkg::CTRL_OFS);
  wire ctrl_wr = bus_wr & sel_ctrl & wb_sel_in[0];

  wire [31:0] status_word = {
    12'h000, cond[csl_pkg::COND_TIMER_EN_N:csl_pkg::COND_ABOVE_UNDERVOLTAGE_LOCKOUT],
    cond[csl_pkg::COND_PIN_PG], cond[csl_pkg::COND_PIN_B], cond[csl_pkg::COND_PIN_A],
    power_good, 4'(state_ff)
  };
  wire [31:0] limit_word = {
    13'h0000, precond_current_out, charge_enable_out, fast_charge_program_out,
    5'h00, input_limit_ma_out
  };

  // Unmapped addresses still acknowledge and read as zero
  wire [31:0] nxt_rdata =
    sel_ctrl ? {30'h00000000, ctrl_ff} :
    (wb_adr_in == csl_pkg::STATUS_OFS) ? status_word :
    (wb_adr_in == csl_pkg::LIMIT_OFS) ? limit_word :
    (wb_adr_in == csl_pkg::TIMER_OFS) ? timer_ms_ff : 32'h00000000;

  always_ff @(posedge clk_sys_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      ack_ff <= bus_req;
      if (bus_req) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ctrl_ff <= csl_pkg::CTRL_RESET;
      restart_ff <= 1'b0;
    end else begin
      restart_ff <= ctrl_wr & wb_dat_in[csl_pkg::CTRL_RESTART_BIT];
      if (ctrl_wr) begin
        ctrl_ff <= wb_dat_in[1:0];
      end
    end
  end

  assign wb_ack_out = ack_ff;
  assign wb_dat_out = rdata_ff;

endmodule : csl_charger_top

// ==== core/csl_pin_sync.sv ====
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps

module csl_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_sys_in, // System clock
  input wire logic reset_n_in, // Synchronised reset, active low
  input wire logic [WIDTH-1:0] pin_in, // Raw pin levels
  output logic [WIDTH-1:0] level_out // Filtered levels
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] stage3_ff;
  logic [WIDTH-1:0] level_ff;
  logic [WIDTH-1:0] nxt_level;

  // ==========================================================
  // Stages; only the second stage reads the first
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stage1_ff <= RESET_VAL;
      stage2_ff <= RESET_VAL;
      stage3_ff <= RESET_VAL;
      level_ff <= RESET_VAL;
    end else begin
      stage1_ff <= pin_in;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      level_ff <= nxt_level;
    end
  end

  // A bit changes only once stages two and three agree
  assign nxt_level = (stage2_ff & ~(stage2_ff ^ stage3_ff)) | (level_ff & (stage2_ff ^ stage3_ff));
  assign level_out = level_ff;

endmodule : csl_pin_sync

// ==== core/csl_pkg.sv ====
// Shared constants and types for the charger status and select logic
package csl_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_MHZ = 125;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int unsigned SAFETY_TIMER_MS = 21600000;

  // ==========================================================
  // Current limits in mA
  localparam logic [10:0] WALL_LIMIT_MA = 11'h708;
  localparam logic [10:0] USB_LOW_LIMIT_MA = 11'h064;
  localparam logic [10:0] USB_HIGH_LIMIT_MA = 11'h1F4;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] LIMIT_OFS = 8'h08;
  localparam logic [7:0] TIMER_OFS = 8'h0C;

  // CTRL fields
  localparam int CTRL_SHUTDOWN_BIT = 0;
  localparam int CTRL_TIMER_OFF_BIT = 1;
  localparam int CTRL_RESTART_BIT = 2;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // STATUS fields
  localparam int STATUS_POWER_GOOD_BIT = 4;
  localparam int STATUS_PIN_LSB = 5;
  localparam int STATUS_COND_LSB = 8;

  // LIMIT fields
  localparam int LIMIT_PROGRAM_BIT = 16;
  localparam int LIMIT_CHARGE_BIT = 17;
  localparam int LIMIT_PRECOND_BIT = 18;

  // ==========================================================
  // Positions of the condition inputs in the synchronised vector
  localparam int COND_ABOVE_UNDERVOLTAGE_LOCKOUT = 0;
  localparam int COND_ABOVE_BAT = 1;
  localparam int COND_BAT_PRESENT = 2;
  localparam int COND_THERMISTOR_SENSE_OK = 3;
  localparam int COND_BELOW_PRECOND = 4;
  localparam int COND_AT_REG_VOLT = 5;
  localparam int COND_TERMINATION = 6;
  localparam int COND_BELOW_RECHARGE = 7;
  localparam int COND_LOW_BATTERY = 8;
  localparam int COND_SOURCE_SEL = 9;
  localparam int COND_USB_LIMIT_SEL = 10;
  localparam int COND_TIMER_EN_N = 11;
  localparam int COND_PIN_A = 12;
  localparam int COND_PIN_B = 13;
  localparam int COND_PIN_PG = 14;
  localparam int COND_WIDTH = 15;
  localparam logic [14:0] COND_RESET = 15'h0000;

  // ==========================================================
  // Charge cycle states
  typedef enum logic [3:0] {
    st_no_input,
    st_shut_bat,
    st_shut_in,
    st_low_bat,
    st_no_bat,
    st_precond,
    st_const_current,
    st_const_voltage,
    st_complete,
    st_temp_fault,
    st_timer_fault
  } csl_state_t;

endpackage : csl_pkg

// ==== core/csl_status_enc.sv ====
// Status encoder: charge state to open-drain pull-down enables
`timescale 1ns/1ps

module csl_status_enc (
  input csl_pkg::csl_state_t state_in, // Current charge state
  output logic pull_a_out, // Pull indicator A low
  output logic pull_b_out, // Pull indicator B low
  output logic pull_pg_out // Pull power-good low
);

  logic [2:0] pulls;

  // ==========================================================
  // Pull pattern {a, b, pg}; a zero bit leaves the pin floating
  always_comb begin
    case (state_in)
      csl_pkg::st_precond,
      csl_pkg::st_const_current,
      csl_pkg::st_const_voltage: pulls = 3'h5;
      csl_pkg::st_temp_fault,
      csl_pkg::st_timer_fault: pulls = 3'h7;
      csl_pkg::st_complete: pulls = 3'h3;
      // shut down on input or no battery
      csl_pkg::st_shut_in,
      csl_pkg::st_no_bat: pulls = 3'h1;
      csl_pkg::st_low_bat: pulls = 3'h4;
      // no input, or shut down on battery
      csl_pkg::st_no_input,
      csl_pkg::st_shut_bat: pulls = 3'h0;
      default: pulls = 3'h0;
    endcase
  end

  assign pull_a_out = pulls[2];
  assign pull_b_out = pulls[1];
  assign pull_pg_out = pulls[0];

endmodule : csl_status_enc

// ==== verification/csl_charger_chk.sv ====
// Checker for status pins, current limits and charge enable
`timescale 1ns/1ps

module csl_charger_chk (
  input wire logic clk_sys_in, // Clock
  input wire logic reset_n_in, // Reset, active low
  input wire logic above_undervoltage_lockout_in, // Above lockout
  input wire logic above_bat_in, // Above battery
  input wire logic low_battery_in, // Low battery
  input wire logic source_select_in, // Source select
  input wire logic usb_limit_select_in, // USB limit select
  input wire logic charge_indicator_a_out, // Drive A
  input wire logic charge_indicator_a_oe_out, // Pull A
  input wire logic charge_indicator_b_out, // Drive B
  input wire logic charge_indicator_b_oe_out, // Pull B
  input wire logic input_power_good_n_out, // Drive PG
  input wire logic input_power_good_n_oe_out, // Pull PG
  input wire logic [10:0] input_limit_ma_out, // Input cap
  input wire logic fast_charge_program_out, // Program applies
  input wire logic charge_enable_out // Charging
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);

  wire logic pull_a = charge_indicator_a_oe_out;
  wire logic pull_b = charge_indicator_b_oe_out;
  wire logic pull_pg = input_power_good_n_oe_out;
  wire logic chg_w = pull_a && !pull_b && pull_pg;

  // ==========================================
  // Pin levels
  a_pins_no_high:
    assert property (!(charge_indicator_a_out | charge_indicator_b_out | input_power_good_n_out))
      else $error("status pin drives high");
  a_lost_power_float:
    assert property ((!above_undervoltage_lockout_in && !low_battery_in)[*8] |=> !(pull_a | pull_b | pull_pg))
      else $error("status pin pulled with no input");
  a_pg_needs_input:
    assert property ((!(above_undervoltage_lockout_in && above_bat_in))[*8] |=> !pull_pg)
      else $error("power good pulled without input");

  // ==========================================
  // Current limits
  a_usb_low_cap:
    assert property ((!source_select_in && !usb_limit_select_in)[*8] |=>
      input_limit_ma_out == csl_pkg::USB_LOW_LIMIT_MA) else $error("low USB cap wrong");
  a_usb_high_cap:
    assert property ((!source_select_in && usb_limit_select_in)[*8] |=>
      input_limit_ma_out == csl_pkg::USB_HIGH_LIMIT_MA) else $error("high USB cap wrong");
  a_wall_cap:
    assert property (source_select_in[*8] |=> fast_charge_program_out &&
      input_limit_ma_out == csl_pkg::WALL_LIMIT_MA) else $error("wall cap wrong");

  // ==========================================
  // Charge path against reported state
  a_fault_stops:
    assert property (pull_a && pull_b && $past(pull_a && pull_b) |-> !charge_enable_out)
      else $error("charging during fault");
  a_complete_off:
    assert property (!pull_a && pull_b && $past(!pull_a && pull_b) |-> !charge_enable_out)
      else $error("charging after completion");
  a_charging_on:
    assert property (chg_w && $past(chg_w) |-> charge_enable_out)
      else $error("charge path off while charging");
endmodule : csl_charger_chk

bind csl_charger_top csl_charger_chk u_chk (
  .clk_sys_in, .reset_n_in, .above_undervoltage_lockout_in, .above_bat_in, .low_battery_in,
  .source_select_in, .usb_limit_select_in, .charge_indicator_a_out,
  .charge_indicator_a_oe_out, .charge_indicator_b_out, .charge_indicator_b_oe_out,
  .input_power_good_n_out, .input_power_good_n_oe_out, .input_limit_ma_out,
  .fast_charge_program_out, .charge_enable_out
);

// ==== verification/csl_host_model.sv ====
// Host side of the status pins: pull-ups and level readback
`timescale 1ns/1ps

module csl_host_model (
  input wire logic [2:0] oe_in, // Pull enables A, B, PG
  input wire logic [2:0] drv_in, // Drive values A, B, PG
  output logic [2:0] level_out // Wire levels A, B, PG
);
  // host pull-ups
  // A released pin reads high; only an enabled low drive lowers it
  assign level_out = ~oe_in | drv_in;
endmodule : csl_host_model

// ==== verification/tb_top.sv ====
// Self-checking bench for the charger status and select logic
`timescale 1ns/1ps

module tb_top;
  logic clk_sys_in;
  logic reset_n_in;
  logic req;
  logic we;
  logic [7:0] adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic ack;
  logic [11:0] cnd;
  logic [2:0] oe;
  logic [2:0] drv;
  logic [2:0] lvl;
  logic [10:0] lim;
  logic fcp;
  logic [31:0] rd;
  logic [31:0] seed;
  logic [1:0] sv;
  int miscompares;
  int compares;

  csl_charger_top #(.TICK_CYCLES(4), .SAFETY_TIMER_MS(5)) u_dut (
    .clk_sys_in, .reset_n_in, .wb_cyc_in(req), .wb_stb_in(req), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .above_undervoltage_lockout_in(cnd[0]), .above_bat_in(cnd[1]),
    .battery_present_in(cnd[2]), .thermistor_sense_ok_in(cnd[3]),
    .below_precond_in(cnd[4]), .at_reg_voltage_in(cnd[5]), .termination_in(cnd[6]),
    .below_recharge_in(cnd[7]), .low_battery_in(cnd[8]), .source_select_in(cnd[9]),
    .usb_limit_select_in(cnd[10]), .safety_timer_enable_n_in(cnd[11]),
    .charge_indicator_a_in(lvl[2]), .charge_indicator_a_out(drv[2]),
    .charge_indicator_a_oe_out(oe[2]), .charge_indicator_b_in(lvl[1]),
    .charge_indicator_b_out(drv[1]), .charge_indicator_b_oe_out(oe[1]),
    .input_power_good_n_in(lvl[0]), .input_power_good_n_out(drv[0]),
    .input_power_good_n_oe_out(oe[0]), .input_limit_ma_out(lim),
    .fast_charge_program_out(fcp), .charge_enable_out(), .precond_current_out()
  );

  csl_host_model u_host (.oe_in(oe), .drv_in(drv), .level_out(lvl));

  // ==========================================
  // Expectations
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  // levels from state code, bits A, B, PG
  function automatic logic [2:0] exp_pins(input logic [3:0] st);
    case (st)
      4'h2, 4'h4: return 3'h6;
      4'h3: return 3'h3;
      4'h5, 4'h6, 4'h7: return 3'h2;
      4'h8: return 3'h4;
      4'h9, 4'hA: return 3'h0;
      default: return 3'h7;
    endcase
  endfunction : exp_pins

  function automatic logic [10:0] exp_limit(input logic [1:0] s);
    if (s[0]) return csl_pkg::WALL_LIMIT_MA;
    return s[1] ? csl_pkg::USB_HIGH_LIMIT_MA : csl_pkg::USB_LOW_LIMIT_MA;
  endfunction : exp_limit

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected word at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_pins(input logic [2:0] got, input logic [2:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected pins at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_pins

  // Entered right after a rising edge; waits for ack without assuming latency
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_sys_in);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk_sys_in);
      n++;
    end
    if (n >= 50) miscompares++;
    rd = rdat;
    req <= 1'b0;
    @(posedge clk_sys_in);
  endtask : wb

  task automatic step(input logic [11:0] c, input logic [2:0] ctl, input logic [3:0] st);
    logic [2:0] p;
    p = exp_pins(st);
    cnd <= c;
    wb(1'b1, 8'h00, {29'h0, ctl});
    repeat (12) @(posedge clk_sys_in);
    wb(1'b0, 8'h04, 32'h0);
    chk_word({28'h0, rd[3:0]}, {28'h0, st});
    chk_word({20'h0, rd[19:8]}, {20'h0, c});
    chk_word({28'h0, rd[7:4]}, {28'h0, p[0], p[1], p[2], c[0] & c[1]});
    chk_pins(lvl, p);
    wb(1'b0, 8'h00, 32'h0);
    chk_word(rd, {30'h0, ctl[1:0]});
    wb(1'b0, 8'h08, 32'h0);
    chk_word({29'h0, rd[18:16]}, {29'h0, (st == 4'h5), (st inside {[4'h5:4'h7]}), c[9]});
  endtask : step

  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  // ==========================================
  // Clock, watchdog and main sequence
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  initial begin
    #200000;
    miscompares++;
    results();
  end

  initial begin
    reset_n_in = 1'b0;
    req = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    cnd = 12'h800;
    seed = 32'h0000CAA9;
    miscompares = 0;
    compares = 0;
    repeat (10) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    wb(1'b1, 8'h10, 32'hFFFFFFFF);
    wb(1'b0, 8'h10, 32'h0);
    chk_word(rd, 32'h0);
    // Four fixed corners first, then random selects
    for (int i = 0; i < 12; i++) begin
      seed = xorshift(seed);
      sv = (i < 4) ? i[1:0] : seed[1:0];
      cnd[10:9] <= sv;
      repeat (12) @(posedge clk_sys_in);
      wb(1'b0, 8'h08, 32'h0);
      chk_word({21'h0, lim}, {21'h0, exp_limit(sv)});
      chk_word({21'h0, rd[10:0]}, {21'h0, exp_limit(sv)});
      chk_word({31'h0, rd[16]}, {31'h0, sv[0]});
      chk_word({31'h0, fcp}, {31'h0, sv[0]});
    end
    step(12'h800, 3'h0, 4'h0);
    step(12'h800, 3'h1, 4'h1);
    step(12'h900, 3'h0, 4'h3);
    step(12'h81F, 3'h0, 4'h5);
    step(12'h80F, 3'h0, 4'h6);
    step(12'h82F, 3'h0, 4'h7);
    step(12'h827, 3'h0, 4'h9);
    step(12'h82F, 3'h0, 4'h7);
    step(12'h86F, 3'h0, 4'h8);
    step(12'h86F, 3'h1, 4'h2);
    step(12'h80B, 3'h0, 4'h4);
    step(12'h00F, 3'h0, 4'h6);
    step(12'h00F, 3'h0, 4'hA);
    step(12'h80F, 3'h4, 4'h6);
    step(12'h80F, 3'h0, 4'h6);
    results();
  end
endmodule : tb_top
